//--- design/pcd_pkg.sv
// Package with constants, register map and state types of the clock divider logic
package pcd_pkg;

   // Structure sizes
   localparam int NUM_DIV = 5;
   localparam int CNT_W = 10;

   // Counter limits: 1..512 for all, 1..256 for non-50% output dividers
   localparam logic [9:0] CNT_MIN = 10'h001;
   localparam logic [9:0] CNT_TOP = 10'h200;
   localparam logic [9:0] NON50_TOP = 10'h100;

   // Register byte addresses
   localparam logic [7:0] ADR_PRE = 8'h00;
   localparam logic [7:0] ADR_FB = 8'h04;
   localparam logic [7:0] ADR_STAT = 8'h08;
   localparam logic [7:0] ADR_DIV0 = 8'h10;
   localparam logic [7:0] ADR_STEP = 8'h04;

   // Field positions
   localparam int STAT_CASC_LSB = 0;
   localparam int STAT_ERR_BIT = 8;
   localparam int DIV_HI_LSB = 0;
   localparam int DIV_LO_LSB = 9;
   localparam int DIV_BYP_BIT = 18;

   // Reset values
   localparam logic [9:0] PRE_RST = 10'h001;
   localparam logic [9:0] FB_RST = 10'h001;
   localparam logic [8:0] HI_RST = 9'h001;
   localparam logic [8:0] LO_RST = 9'h001;
   localparam logic BYP_RST = 1'b0;

   // Timing of the oscillator clock
   localparam int CLK_PERIOD_NS = 40;

   // One output divider setting, laid out as its register word
   typedef struct packed {
      logic byp;
      logic [8:0] lo;
      logic [8:0] hi;
   } pcd_div_cfg_s;

   // State of the top module
   typedef struct packed {
      logic [9:0] pre_val;
      logic [9:0] fb_val;
      pcd_div_cfg_s [NUM_DIV-1:0] div;
      logic err;
      logic ack;
      logic [31:0] rdat;
      logic [2:0] ref_sync;
      logic [9:0] pre_cnt;
      logic [9:0] fb_cnt;
      logic ref_tick;
      logic fb_tick;
   } pcd_top_s;

   // State of one output divider
   typedef struct packed {
      logic [9:0] cnt;
      logic level;
   } pcd_div_s;

endpackage

//--- design/pcd_out_div.sv
// Output post-scale divider with separate high and low counts
`timescale 1ns/1ps
module pcd_out_div (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Setting and input rate
   input wire pcd_pkg::pcd_div_cfg_s cfg_i,
   input wire logic en_i,
   // Output level and period boundary
   output logic level_o,
   output logic tick_o
);

   pcd_pkg::pcd_div_s s_reg;
   pcd_pkg::pcd_div_s s_next;
   logic [9:0] total;
   logic tick;

   // Ratio is the sum of both counts
   assign total = {1'b0, cfg_i.hi} + {1'b0, cfg_i.lo};

   // Count input events; high for hi events, then low for lo events
   always_comb begin
      s_next = s_reg;
      tick = 1'b0;
      if (en_i) begin
         if (cfg_i.byp) begin
            s_next.cnt = '0;
            tick = 1'b1;
         end else if (s_reg.cnt >= total - 10'h001) begin
            // Also wraps at once when a smaller ratio is loaded mid-period
            s_next.cnt = '0;
            tick = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + 10'h001;
         end
      end
      if (cfg_i.byp) begin
         s_next.level = en_i;
      end else begin
         s_next.level = (s_next.cnt < {1'b0, cfg_i.hi});
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign level_o = s_reg.level;
   assign tick_o = tick;

   // Checking helpers: input events since the last boundary, and setting changes
   logic [9:0] gap_q;
   logic chg_q;
   pcd_pkg::pcd_div_cfg_s cfg_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gap_q <= '0;
         chg_q <= 1'b1;
         cfg_q <= '0;
      end else begin
         cfg_q <= cfg_i;
         if (tick) begin
            gap_q <= '0;
            chg_q <= 1'b0;
         end else begin
            if (en_i) begin
               gap_q <= gap_q + 10'h001;
            end
            if (cfg_i != cfg_q) begin
               chg_q <= 1'b1;
            end
         end
      end
   end

   div_period_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (tick && !cfg_i.byp && !chg_q && cfg_i == cfg_q) |-> gap_q == total - 10'h001)
      else $error("divider period differs from high plus low");

   bypass_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cfg_i.byp && $stable(cfg_i.byp)) |=> level_o == $past(en_i))
      else $error("bypassed divider does not pass its input");

endmodule

//--- design/pcd_clk_div_top.sv
// Counter logic of the frequency synthesizer: pre-scale, feedback and output dividers
// Behaviour
// - One pre-scale and one feedback counter, 1..512.
// - Pre-scale divider divides only, no duty.
// - Five independent output dividers per synthesizer.
// - Output divider 1..512 at 50% duty; the code gives 50% only at even ratios 2..512, with high equal to low.
// - Non-50% duty limits divider to 1..256.
// - Divide ratio is high plus low count.
// - Oscillator runs at input times M over N.
// - Each output has its own oscillator divider.
// - Output dividers may chain beyond 512.
// - Chained dividers divide by product of settings.
// - Cascading fixed at build, not by software.
// - Duty set by separate high and low counts.
// - Duty step is 50% over divide value; the code steps by whole counts, 100% over the ratio.
// - Only divider zero drives external clock output.
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module pcd_clk_div_top #(
   // Bit k set: divider k counts the boundaries of divider k-1 (bit 0 unused)
   parameter logic [4:0] CASCADE = 5'h00
) (
   // Clock and reset; clk_i stands for the oscillator clock
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Reference clock pin
   input wire logic ref_clk_i,
   // Phase detector side
   output logic ref_div_tick_o,
   output logic fb_div_tick_o,
   // Clock outputs
   output logic [4:0] global_clock_network_o,
   output logic ext_clk_o
);

   pcd_pkg::pcd_top_s s_reg;
   pcd_pkg::pcd_top_s s_next;
   logic [4:0] div_en;
   logic [4:0] div_tick;
   logic [4:0] div_level;
   logic ref_edge;
   logic bus_req;
   logic [31:0] wr_word;
   logic [31:0] old_word;
   logic err_set;
   logic err_clr;

   // Register map, byte addresses, address bits 1:0 ignored:
   //   0x00 pre-scale value N, bits 9:0, 1..512
   //   0x04 feedback value M, bits 9:0, 1..512
   //   0x08 status: bits 4:0 build-time cascade map (bit 0 always 0),
   //        bit 8 sticky error, write one to clear; a new error in that cycle wins
   //   0x10 + 4k output divider k: bits 8:0 high count, bits 17:9 low count,
   //        bit 18 bypass (divide by one)
   // Every access is answered one cycle after it is taken; out-of-range values
   // are acknowledged, dropped and flagged, so the running ratio never goes bad.
   // Unmapped words read zero and ignore writes.

   // Keep only the bytes that sel enables
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = dat[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Range check of a pre-scale or feedback value
   function automatic logic range_ok(input logic [9:0] v);
      return (v >= pcd_pkg::CNT_MIN) && (v <= pcd_pkg::CNT_TOP);
   endfunction

   // Range check of an output divider setting
   function automatic logic div_ok(input pcd_pkg::pcd_div_cfg_s c);
      logic [9:0] sum;
      sum = {1'b0, c.hi} + {1'b0, c.lo};
      if (c.byp) begin
         return 1'b1;
      end
      if (c.hi == 9'h000 || c.lo == 9'h000) begin
         return 1'b0;
      end
      if (c.hi == c.lo) begin
         return sum <= pcd_pkg::CNT_TOP;
      end
      return sum <= pcd_pkg::NON50_TOP;
   endfunction

   // Register word at the current address
   function automatic logic [31:0] read_word(input pcd_pkg::pcd_top_s s, input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (a == pcd_pkg::ADR_PRE) begin
         w[9:0] = s.pre_val;
      end else if (a == pcd_pkg::ADR_FB) begin
         w[9:0] = s.fb_val;
      end else if (a == pcd_pkg::ADR_STAT) begin
         w[pcd_pkg::STAT_CASC_LSB +: 5] = {CASCADE[4:1], 1'b0};
         w[pcd_pkg::STAT_ERR_BIT] = s.err;
      end else begin
         for (int k = 0; k < pcd_pkg::NUM_DIV; k++) begin
            if (a == pcd_pkg::ADR_DIV0 + pcd_pkg::ADR_STEP * 8'(k)) begin
               w[18:0] = s.div[k];
            end
         end
      end
      return w;
   endfunction

   assign bus_req = wb_cyc_i && wb_stb_i && !s_reg.ack;
   // Second synchroniser flop against the third one gives the rising edge
   assign ref_edge = s_reg.ref_sync[1] && !s_reg.ref_sync[2];
   assign old_word = read_word(s_reg, {wb_adr_i[7:2], 2'b00});
   assign wr_word = merge(old_word, wb_dat_i, wb_sel_i);

   // Next state: synchroniser, pre-scale and feedback counters, registers
   always_comb begin
      s_next = s_reg;
      err_set = 1'b0;
      err_clr = 1'b0;
      s_next.ack = 1'b0;
      s_next.ref_sync = {s_reg.ref_sync[1:0], ref_clk_i};

      // Pre-scale: one tick every N reference edges, no duty setting
      s_next.ref_tick = 1'b0;
      if (ref_edge) begin
         if (s_reg.pre_cnt >= s_reg.pre_val - 10'h001) begin
            s_next.pre_cnt = '0;
            s_next.ref_tick = 1'b1;
         end else begin
            s_next.pre_cnt = s_reg.pre_cnt + 10'h001;
         end
      end

      // Feedback: one tick every M oscillator cycles; the loop matches it to ref_tick
      s_next.fb_tick = 1'b0;
      if (s_reg.fb_cnt >= s_reg.fb_val - 10'h001) begin
         s_next.fb_cnt = '0;
         s_next.fb_tick = 1'b1;
      end else begin
         s_next.fb_cnt = s_reg.fb_cnt + 10'h001;
      end

      // Wishbone: answer every request one cycle later, unmapped reads give zero
      if (bus_req) begin
         s_next.ack = 1'b1;
         s_next.rdat = old_word;
         if (wb_we_i) begin
            case ({wb_adr_i[7:2], 2'b00})
               pcd_pkg::ADR_PRE: begin
                  if (range_ok(wr_word[9:0])) begin
                     s_next.pre_val = wr_word[9:0];
                  end else begin
                     err_set = 1'b1;
                  end
               end
               pcd_pkg::ADR_FB: begin
                  if (range_ok(wr_word[9:0])) begin
                     s_next.fb_val = wr_word[9:0];
                  end else begin
                     err_set = 1'b1;
                  end
               end
               pcd_pkg::ADR_STAT: begin
                  // Cascade bits are read only; only the error flag clears
                  err_clr = wb_sel_i[1] && wb_dat_i[pcd_pkg::STAT_ERR_BIT];
               end
               default: begin
                  for (int k = 0; k < pcd_pkg::NUM_DIV; k++) begin
                     if ({wb_adr_i[7:2], 2'b00} == pcd_pkg::ADR_DIV0
                         + pcd_pkg::ADR_STEP * 8'(k)) begin
                        // Rejected setting keeps the old one, so no bad ratio runs
                        if (div_ok(wr_word[18:0])) begin
                           s_next.div[k] = wr_word[18:0];
                        end else begin
                           err_set = 1'b1;
                        end
                     end
                  end
               end
            endcase
         end
      end
      // A new error in the clearing cycle is kept
      s_next.err = (s_reg.err && !err_clr) || err_set;
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= '0;
         s_reg.pre_val <= pcd_pkg::PRE_RST;
         s_reg.fb_val <= pcd_pkg::FB_RST;
         for (int k = 0; k < pcd_pkg::NUM_DIV; k++) begin
            s_reg.div[k] <= {pcd_pkg::BYP_RST, pcd_pkg::LO_RST, pcd_pkg::HI_RST};
         end
      end else begin
         s_reg <= s_next;
      end
   end

   // Five output dividers; each counts the oscillator or, when chained, its neighbour
   generate
      for (genvar k = 0; k < pcd_pkg::NUM_DIV; k++) begin : g_div
         if (k == 0) begin : g_first
            assign div_en[k] = 1'b1;
         end else begin : g_next
            // Fixed at build time, so a chain cannot break mid-run
            assign div_en[k] = CASCADE[k] ? div_tick[k-1] : 1'b1;
         end
         pcd_out_div u_div (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .cfg_i(s_reg.div[k]),
            .en_i(div_en[k]),
            .level_o(div_level[k]),
            .tick_o(div_tick[k])
         );
      end
   endgenerate

   // Outputs
   assign wb_ack_o = s_reg.ack;
   assign wb_dat_o = s_reg.rdat;
   assign ref_div_tick_o = s_reg.ref_tick;
   assign fb_div_tick_o = s_reg.fb_tick;
   assign global_clock_network_o = div_level;
   assign ext_clk_o = div_level[0];

   // Checks on the bus, the counters and the outputs; each watches what the
   // logic above drives and is switched off while reset is applied
   // Acknowledge is a single-cycle pulse
   ack_single_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");

   // Every taken request is answered on the next edge
   ack_reply_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered in one cycle");

   // The dedicated pin carries divider zero and nothing else
   ext_clock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ext_clk_o == global_clock_network_o[0])
      else $error("external clock not from divider zero");

   // Pre-scale values outside 1..512 are flagged and dropped
   pre_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (bus_req && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[1:0] == 2'h3
       && (wb_dat_i[9:0] == 10'h000 || wb_dat_i[9:0] > 10'h200))
      |=> s_reg.err && $stable(s_reg.pre_val))
      else $error("out of range pre-scale value accepted");

   // The Nth reference edge gives the tick and restarts the count
   pre_tick_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ref_edge && s_reg.pre_cnt == s_reg.pre_val - 10'h001)
      |=> ref_div_tick_o && s_reg.pre_cnt == 10'h000)
      else $error("pre-scale tick missing after N edges");

   // With M of one the feedback tick stands on every cycle
   fb_one_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_reg.fb_val == 10'h001) [*2] |=> fb_div_tick_o)
      else $error("feedback of one does not tick every cycle");

   // Cascade map reads back as built, whatever was written
   casc_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (bus_req && !wb_we_i && wb_adr_i[7:2] == 6'h02)
      |=> wb_dat_o[4:0] == {CASCADE[4:1], 1'b0})
      else $error("cascade readback differs from build setting");

   // Uneven counts summing past 256 are refused on divider zero
   non50_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (bus_req && wb_we_i && wb_adr_i[7:2] == 6'h04 && wb_sel_i == 4'hf && !wb_dat_i[18]
       && wb_dat_i[8:0] != wb_dat_i[17:9]
       && ({1'b0, wb_dat_i[8:0]} + {1'b0, wb_dat_i[17:9]}) > 10'h100)
      |=> $stable(s_reg.div[0]) && s_reg.err)
      else $error("non-50 percent setting above 256 accepted");

   // A feedback value outside 1..512 is flagged and dropped
   fb_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (bus_req && wb_we_i && wb_adr_i[7:2] == 6'h01 && wb_sel_i[1:0] == 2'h3
       && (wb_dat_i[9:0] == 10'h000 || wb_dat_i[9:0] > 10'h200))
      |=> s_reg.err && $stable(s_reg.fb_val))
      else $error("out of range feedback value accepted");

   // Read data of the pre-scale word is the stored value, upper bits zero
   pre_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (bus_req && !wb_we_i && wb_adr_i[7:2] == 6'h00)
      |=> wb_dat_o == {22'h000000, s_reg.pre_val})
      else $error("pre-scale readback differs from stored value");

   // Words past the last divider read zero
   unmapped_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (bus_req && !wb_we_i && wb_adr_i[7:2] > 6'h08)
      |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped word reads non-zero");

   // Read data holds until the next request is taken
   rdat_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !bus_req |=> $stable(wb_dat_o))
      else $error("read data changed without a request");

   // The error flag stays until software clears it
   err_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_reg.err && !err_clr) |=> s_reg.err)
      else $error("error flag lost without a clear");

   // A new error is never lost
   err_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      err_set |=> s_reg.err)
      else $error("new error not flagged");

   // Reference edges are two cycles apart at least, so the tick lasts one cycle
   ref_single_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ref_div_tick_o |=> !ref_div_tick_o)
      else $error("pre-scale tick longer than one cycle");

   // Pre-scale count stays below N while N is unchanged
   pre_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_reg.pre_cnt < s_reg.pre_val) ##1 $stable(s_reg.pre_val)
      |-> s_reg.pre_cnt < s_reg.pre_val)
      else $error("pre-scale count ran past N");

   // Feedback count stays below M while M is unchanged
   fb_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_reg.fb_cnt < s_reg.fb_val) ##1 $stable(s_reg.fb_val)
      |-> s_reg.fb_cnt < s_reg.fb_val)
      else $error("feedback count ran past M");

   // A bypass setting is always accepted, whatever the counts
   byp_accept_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (bus_req && wb_we_i && wb_adr_i[7:2] == 6'h08 && wb_sel_i == 4'hf && wb_dat_i[18])
      |=> s_reg.div[4].byp)
      else $error("bypass setting refused");

endmodule

//--- tb/pcd_ref_src.sv
// Reference clock source standing at the far side of the pre-scale divider
`timescale 1ns/1ps
module pcd_ref_src #(
   parameter int HALF_NS = 160
) (
   // Run control
   input wire logic run_i,
   // Reference clock pin
   output logic ref_clk_o
);
   // Parked low while stopped, so no stray edge reaches the pre-scale counter
   initial begin
      ref_clk_o = 1'b0;
      #7;
      forever begin
         #(HALF_NS);
         ref_clk_o = run_i ? ~ref_clk_o : 1'b0;
      end
   end
endmodule

//--- tb/testbench.sv
// Self-checking bench of the synthesizer counter logic
`timescale 1ns/1ps
module testbench;
   logic clk_i = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat_o;
   logic ack;
   logic ref_clk;
   logic run = 1'b0;
   logic ref_tick;
   logic fb_tick;
   logic [4:0] gcn;
   logic ext_clk;
   logic [31:0] q;
   logic [3:0] bsel = 4'hf;
   int error_cnt = 0;
   int samples_checked = 0;
   int h;
   int l;
   int g;
   // Divider settings: divider 1 is chained behind divider 0
   logic [8:0] hi_t [5] = '{9'h003, 9'h001, 9'h001, 9'h100, 9'h005};
   logic [8:0] lo_t [5] = '{9'h001, 9'h001, 9'h009, 9'h100, 9'h005};
   int exp_h [5] = '{3, 4, 1, 256, 5};
   int exp_l [5] = '{1, 4, 9, 256, 5};

   always #20 clk_i = ~clk_i;

   pcd_clk_div_top #(.CASCADE(5'h02)) pcd_clk_div_top_i (
      .clk_i(clk_i), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .ref_clk_i(ref_clk), .ref_div_tick_o(ref_tick), .fb_div_tick_o(fb_tick),
      .global_clock_network_o(gcn), .ext_clk_o(ext_clk)
   );

   pcd_ref_src pcd_ref_src_i (.run_i(run), .ref_clk_o(ref_clk));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One classic cycle; the request stands until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= bsel;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) chk(1'b0, 1'b1, "bus ack");
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(q, exp, "register read");
   endtask

   // Length of the next full high and low phase of divider k, in clock cycles
   task automatic meas(input int k);
      int n;
      n = 0;
      h = 0;
      l = 0;
      do begin @(posedge clk_i); n++; end while (gcn[k] !== 1'b0 && n < 3000);
      do begin @(posedge clk_i); n++; end while (gcn[k] !== 1'b1 && n < 3000);
      while (gcn[k] === 1'b1 && h < 3000) begin @(posedge clk_i); h++; end
      while (gcn[k] === 1'b0 && l < 3000) begin @(posedge clk_i); l++; end
   endtask

   // Cycles between two pulses of the selected tick
   task automatic gap(input logic use_ref);
      g = 0;
      do @(posedge clk_i); while ((use_ref ? ref_tick : fb_tick) !== 1'b1);
      do begin @(posedge clk_i); g++; end while ((use_ref ? ref_tick : fb_tick) !== 1'b1);
   endtask

   task automatic complete_run;
      $display("Comparisons %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // External pin must always follow divider zero
   always @(posedge clk_i) begin
      if (rst_n && ext_clk !== gcn[0]) chk(ext_clk, gcn[0], "external clock");
   end

   // A hang is cut short well past the expected run length
   initial begin
      #2400000;
      chk(1'b0, 1'b1, "watchdog");
      complete_run();
   end

   initial begin
      repeat (10) @(posedge clk_i);
      chk({ref_tick, fb_tick, gcn}, 32'h0, "outputs in reset");
      rst_n <= 1'b1;
      rd_chk(pcd_pkg::ADR_PRE, 32'h1);
      rd_chk(pcd_pkg::ADR_FB, 32'h1);
      rd_chk(pcd_pkg::ADR_STAT, 32'h2);
      for (int k = 0; k < 5; k++) rd_chk(pcd_pkg::ADR_DIV0 + 8'(4 * k), 32'h201);
      // Cascade field is build-time only
      xfer(1'b1, pcd_pkg::ADR_STAT, 32'h1f);
      rd_chk(pcd_pkg::ADR_STAT, 32'h2);
      // Unmapped place reads zero and keeps nothing
      xfer(1'b1, 8'h40, 32'hffff);
      rd_chk(8'h40, 32'h0);
      // Counter range boundaries
      xfer(1'b1, pcd_pkg::ADR_PRE, 32'h200);
      rd_chk(pcd_pkg::ADR_PRE, 32'h200);
      xfer(1'b1, pcd_pkg::ADR_PRE, 32'h0);
      xfer(1'b1, pcd_pkg::ADR_PRE, 32'h201);
      rd_chk(pcd_pkg::ADR_PRE, 32'h200);
      rd_chk(pcd_pkg::ADR_STAT, 32'h102);
      xfer(1'b1, pcd_pkg::ADR_STAT, 32'h100);
      rd_chk(pcd_pkg::ADR_STAT, 32'h2);
      // Five dividers, high and low counts, chaining
      for (int k = 0; k < 5; k++) begin
         xfer(1'b1, pcd_pkg::ADR_DIV0 + 8'(4 * k), {14'h0, lo_t[k], hi_t[k]});
      end
      for (int k = 0; k < 5; k++) begin
         meas(k);
         chk(h, exp_h[k], "high phase");
         chk(l, exp_l[k], "low phase");
      end
      // Uneven counts beyond 256, and 50% beyond 512, are refused
      xfer(1'b1, pcd_pkg::ADR_DIV0 + 8'h08, {14'h0, 9'h064, 9'h0c8});
      rd_chk(pcd_pkg::ADR_DIV0 + 8'h08, {14'h0, lo_t[2], hi_t[2]});
      rd_chk(pcd_pkg::ADR_STAT, 32'h102);
      xfer(1'b1, pcd_pkg::ADR_DIV0 + 8'h0c, {14'h0, 9'h12c, 9'h12c});
      rd_chk(pcd_pkg::ADR_DIV0 + 8'h0c, 32'h20100);
      // Uneven setting beyond 256 on divider zero, with the flag cleared first
      xfer(1'b1, pcd_pkg::ADR_STAT, 32'h100);
      xfer(1'b1, pcd_pkg::ADR_DIV0, {14'h0, 9'h064, 9'h0c8});
      rd_chk(pcd_pkg::ADR_DIV0, {14'h0, lo_t[0], hi_t[0]});
      rd_chk(pcd_pkg::ADR_STAT, 32'h102);
      // Divide by one keeps the output high on every cycle
      xfer(1'b1, pcd_pkg::ADR_DIV0 + 8'h10, 32'h40000);
      repeat (3) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         chk(gcn[4], 1'b1, "bypass level");
      end
      // Feedback and reference counters
      xfer(1'b1, pcd_pkg::ADR_FB, 32'h5);
      gap(1'b0);
      chk(g, 5, "feedback period");
      xfer(1'b1, pcd_pkg::ADR_FB, 32'h0);
      rd_chk(pcd_pkg::ADR_FB, 32'h5);
      xfer(1'b1, pcd_pkg::ADR_PRE, 32'h3);
      run <= 1'b1;
      gap(1'b1);
      gap(1'b1);
      chk(g, 24, "reference period");
      // Only enabled bytes change: byte 1 of the pre-scale word
      bsel = 4'h2;
      xfer(1'b1, pcd_pkg::ADR_PRE, 32'hffff_0105);
      bsel = 4'hf;
      rd_chk(pcd_pkg::ADR_PRE, 32'h103);
      complete_run();
   end
endmodule
